/* acr_pkg.sv */
// acr_pkg: register map, field layout and reset values of the channel calibration bank
// assumes a wishbone slave with 32-bit data; each register is one aligned word
package acr_pkg;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned IDX_W  = 4;
    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_THR_HIGH = 4'h7;
    localparam logic [3:0] IDX_THR_LOW  = 4'h8;
    localparam logic [3:0] IDX_CHANNEL0_CONFIG  = 4'h9;
    localparam logic [3:0] IDX_OCAL_HI  = 4'ha;
    localparam logic [3:0] IDX_OCAL_LO  = 4'hb;
    localparam logic [3:0] IDX_GCAL_HI  = 4'hc;
    localparam logic [3:0] IDX_GCAL_LO  = 4'hd;
    // reset values
    localparam logic [15:0] RST_ZERO    = 16'h0000;
    localparam logic [15:0] RST_GCAL_HI = 16'h8000;
    // writable bit masks, reserved bits read zero
    localparam logic [15:0] MASK_FULL    = 16'hffff;
    localparam logic [15:0] MASK_THR_LOW = 16'hff0f;
    localparam logic [15:0] MASK_CH_CFG  = 16'hffc7;
    localparam logic [15:0] MASK_CAL_LO  = 16'hff00;
    // field positions
    localparam int unsigned THR_LOW_LSB = 8;
    localparam int unsigned PHASE_LSB   = 6;
    localparam int unsigned PHASE_W     = 10;
    localparam int unsigned DCOFF_BIT   = 2;
    localparam int unsigned CAL_W       = 24;
    localparam logic [3:0]  COEFF_BYPASS = 4'h0;
    // shift for code 1 is 2 (1/4); coefficient is 2^-(code+1)
    localparam logic [4:0]  COEFF_SHIFT_BASE = 5'h01;
    // input selector codes
    localparam logic [1:0] MUX_PINS  = 2'h0;
    localparam logic [1:0] MUX_SHORT = 2'h1;
    localparam logic [1:0] MUX_TPOS  = 2'h2;
    localparam logic [1:0] MUX_TNEG  = 2'h3;
endpackage

/* acr_reg.sv */
// acr_reg: one 16-bit register with a writable bit mask and byte lanes
// assumes the caller decodes the address and gives a single-cycle write strobe
`timescale 1ns/100ps
`default_nettype none
module acr_reg #(
    parameter logic [15:0] RESET_VAL = 16'h0000,
    parameter logic [15:0] WR_MASK   = 16'hffff
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wr_i,
    input  wire logic [1:0]  sel_i,
    input  wire logic [15:0] dat_i,
    output logic      [15:0] q_o
);
    logic [15:0] next_q;
    logic [15:0] lane;

    always_comb begin
        lane   = {{8{sel_i[1]}}, {8{sel_i[0]}}} & WR_MASK;
        next_q = q_o;
        if (wr_i) begin
            next_q = (q_o & ~lane) | (dat_i & lane);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_o <= RESET_VAL & WR_MASK;
        end else begin
            q_o <= next_q;
        end
    end
endmodule
`default_nettype wire

/* acr_regs.sv */
// acr_regs: calibration and configuration registers for converter channel 0
// assumes a classic wishbone master; registers sit at four times their index
//
// Functional notes
// - threshold high register holds threshold bits 23:8
// - threshold low upper byte holds bits 7:0
// - filter code zero bypasses, else 1/2^(n+1)
// - phase delay is signed ten-bit modulator cycles
// - channel disable bit forces dc removal off
// - input selector picks pins, short, test signals
// - offset value joins high word and low byte
// - gain value joins words, high resets 8000h
// - channel config at 9h, calibration through Dh
`timescale 1ns/100ps
`default_nettype none
module acr_regs (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [5:2]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic      [23:0] detect_threshold_o,
    output logic             dc_removal_bypass_o,
    output logic      [4:0]  dc_removal_shift_o,
    output logic      [9:0]  channel0_phase_delay_o,
    output logic      [1:0]  channel0_input_select_o,
    output logic             channel0_short_o,
    output logic             channel0_test_pos_o,
    output logic             channel0_test_neg_o,
    output logic      [23:0] channel0_offset_o,
    output logic      [23:0] channel0_gain_o
);
    logic        req;
    logic [15:0] detect_threshold_upper_r;
    logic [15:0] thr_low_r;
    logic [15:0] cfg_r;
    logic [15:0] ocal_hi_r;
    logic [15:0] ocal_lo_r;
    logic [15:0] gcal_hi_r;
    logic [15:0] gcal_lo_r;
    logic [31:0] next_dat;
    logic        next_ack;
    logic [23:0] next_thr;
    logic        next_bypass;
    logic [4:0]  next_shift;
    logic [1:0]  next_mux;
    logic [23:0] next_ocal;
    logic [23:0] next_gcal;

    // one write strobe per access; ack drops the cycle after
    assign req = cyc_i & stb_i & ~ack_o;

    localparam int unsigned THR_LOW_LSB_C = acr_pkg::THR_LOW_LSB;

    function automatic logic hit(input logic [3:0] idx);
        return req & we_i & (adr_i == idx);
    endfunction

    function automatic logic [23:0] join_cal(input logic [15:0] hi, input logic [15:0] lo);
        return {hi, lo[15:THR_LOW_LSB_C]};
    endfunction

    acr_reg #(.RESET_VAL(acr_pkg::RST_ZERO), .WR_MASK(acr_pkg::MASK_FULL)) u_thr_hi (
        .clk_i(clk_i), .rst_i(rst_i), .wr_i(hit(acr_pkg::IDX_THR_HIGH)),
        .sel_i(sel_i[1:0]), .dat_i(dat_i[15:0]), .q_o(detect_threshold_upper_r)
    );
    acr_reg #(.RESET_VAL(acr_pkg::RST_ZERO), .WR_MASK(acr_pkg::MASK_THR_LOW)) u_thr_lo (
        .clk_i(clk_i), .rst_i(rst_i), .wr_i(hit(acr_pkg::IDX_THR_LOW)),
        .sel_i(sel_i[1:0]), .dat_i(dat_i[15:0]), .q_o(thr_low_r)
    );
    acr_reg #(.RESET_VAL(acr_pkg::RST_ZERO), .WR_MASK(acr_pkg::MASK_CH_CFG)) u_cfg (
        .clk_i(clk_i), .rst_i(rst_i), .wr_i(hit(acr_pkg::IDX_CHANNEL0_CONFIG)),
        .sel_i(sel_i[1:0]), .dat_i(dat_i[15:0]), .q_o(cfg_r)
    );
    acr_reg #(.RESET_VAL(acr_pkg::RST_ZERO), .WR_MASK(acr_pkg::MASK_FULL)) u_ocal_hi (
        .clk_i(clk_i), .rst_i(rst_i), .wr_i(hit(acr_pkg::IDX_OCAL_HI)),
        .sel_i(sel_i[1:0]), .dat_i(dat_i[15:0]), .q_o(ocal_hi_r)
    );
    acr_reg #(.RESET_VAL(acr_pkg::RST_ZERO), .WR_MASK(acr_pkg::MASK_CAL_LO)) u_ocal_lo (
        .clk_i(clk_i), .rst_i(rst_i), .wr_i(hit(acr_pkg::IDX_OCAL_LO)),
        .sel_i(sel_i[1:0]), .dat_i(dat_i[15:0]), .q_o(ocal_lo_r)
    );
    acr_reg #(.RESET_VAL(acr_pkg::RST_GCAL_HI), .WR_MASK(acr_pkg::MASK_FULL)) u_gcal_hi (
        .clk_i(clk_i), .rst_i(rst_i), .wr_i(hit(acr_pkg::IDX_GCAL_HI)),
        .sel_i(sel_i[1:0]), .dat_i(dat_i[15:0]), .q_o(gcal_hi_r)
    );
    acr_reg #(.RESET_VAL(acr_pkg::RST_ZERO), .WR_MASK(acr_pkg::MASK_CAL_LO)) u_gcal_lo (
        .clk_i(clk_i), .rst_i(rst_i), .wr_i(hit(acr_pkg::IDX_GCAL_LO)),
        .sel_i(sel_i[1:0]), .dat_i(dat_i[15:0]), .q_o(gcal_lo_r)
    );

    always_comb begin
        next_ack = req;
        next_dat = 32'h0000_0000;
        // unmapped indices still ack and read zero, so software never hangs
        if (req & ~we_i) begin
            unique case (adr_i)
                acr_pkg::IDX_THR_HIGH: next_dat[15:0] = detect_threshold_upper_r;
                acr_pkg::IDX_THR_LOW:  next_dat[15:0] = thr_low_r;
                acr_pkg::IDX_CHANNEL0_CONFIG:  next_dat[15:0] = cfg_r;
                acr_pkg::IDX_OCAL_HI:  next_dat[15:0] = ocal_hi_r;
                acr_pkg::IDX_OCAL_LO:  next_dat[15:0] = ocal_lo_r;
                acr_pkg::IDX_GCAL_HI:  next_dat[15:0] = gcal_hi_r;
                acr_pkg::IDX_GCAL_LO:  next_dat[15:0] = gcal_lo_r;
                default:               next_dat = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        next_thr    = {detect_threshold_upper_r, thr_low_r[15:THR_LOW_LSB_C]};
        // channel disable overrides the shared selector
        next_bypass = (thr_low_r[3:0] == acr_pkg::COEFF_BYPASS) |
                      cfg_r[acr_pkg::DCOFF_BIT];
        next_shift  = next_bypass ? 5'h00
                                  : 5'({1'b0, thr_low_r[3:0]} + acr_pkg::COEFF_SHIFT_BASE);
        next_mux    = cfg_r[1:0];
        next_ocal   = join_cal(ocal_hi_r, ocal_lo_r);
        next_gcal   = join_cal(gcal_hi_r, gcal_lo_r);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o                   <= 1'b0;
            dat_o                   <= 32'h0000_0000;
            detect_threshold_o      <= 24'h00_0000;
            dc_removal_bypass_o     <= 1'b1;
            dc_removal_shift_o      <= 5'h00;
            channel0_phase_delay_o  <= 10'h000;
            channel0_input_select_o <= acr_pkg::MUX_PINS;
            channel0_short_o        <= 1'b0;
            channel0_test_pos_o     <= 1'b0;
            channel0_test_neg_o     <= 1'b0;
            channel0_offset_o       <= 24'h00_0000;
            channel0_gain_o         <= 24'h80_0000;
        end else begin
            ack_o                   <= next_ack;
            dat_o                   <= next_dat;
            detect_threshold_o      <= next_thr;
            dc_removal_bypass_o     <= next_bypass;
            dc_removal_shift_o      <= next_shift;
            // signed two's complement, passed as raw bits to the delay line
            channel0_phase_delay_o  <= cfg_r[acr_pkg::PHASE_LSB +: acr_pkg::PHASE_W];
            channel0_input_select_o <= next_mux;
            channel0_short_o        <= next_mux == acr_pkg::MUX_SHORT;
            channel0_test_pos_o     <= next_mux == acr_pkg::MUX_TPOS;
            channel0_test_neg_o     <= next_mux == acr_pkg::MUX_TNEG;
            channel0_offset_o       <= next_ocal;
            channel0_gain_o         <= next_gcal;
        end
    end
endmodule
`default_nettype wire

/* acr_regs_bench.sv */
// acr_regs_bench: self-checking bench for the channel calibration bank
// assumes acr_pkg and acr_regs compiled first; bench is the wishbone master
`timescale 1ns/100ps
`default_nettype none
module acr_regs_bench;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [5:2]  adr_i = '0;
    logic [3:0]  sel_i = '0;
    logic [31:0] dat_i = '0, dat_o, q;
    logic        ack_o, dc_removal_bypass_o, channel0_short_o, channel0_test_pos_o;
    logic        channel0_test_neg_o;
    logic [23:0] detect_threshold_o, channel0_offset_o, channel0_gain_o;
    logic [4:0]  dc_removal_shift_o;
    logic [9:0]  channel0_phase_delay_o;
    logic [1:0]  channel0_input_select_o;
    logic [15:0] rv [7] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h8000, 16'h0};
    logic [15:0] wm [7] = '{16'hffff, 16'hff0f, 16'hffc7, 16'hffff, 16'hff00, 16'hffff, 16'hff00};
    int          fail_count = 0, total_checks = 0;
    acr_regs acr_regs_i (.*);
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    // one classic cycle; held until ack is sampled high
    task automatic xfer(input logic w, input logic [3:0] a, input logic [15:0] d,
                        input logic [3:0] s = 4'hf);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, a, s, 16'h0, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        {cyc_i, stb_i, we_i} <= 3'h0;
    endtask
    // derived outputs must show the reset image before any write
    task automatic t_reset;
        @(posedge clk_i);
        chk({8'h0, detect_threshold_o}, 32'h0);
        chk({26'h0, dc_removal_bypass_o, dc_removal_shift_o}, {26'h0, 1'b1, 5'h00});
        chk({17'h0, channel0_phase_delay_o, channel0_input_select_o, channel0_short_o,
             channel0_test_pos_o, channel0_test_neg_o}, 32'h0);
        chk({8'h0, channel0_offset_o}, 32'h0);
        chk({8'h0, channel0_gain_o}, 32'h800000);
    endtask
    // byte lanes write their own half only
    task automatic t_lanes;
        xfer(1'b1, 4'ha, 16'habcd, 4'h1);
        xfer(1'b0, 4'ha, 16'h0);
        chk(q, 32'h0000_12cd);
        xfer(1'b1, 4'ha, 16'hef00, 4'h2);
        xfer(1'b0, 4'ha, 16'h0);
        chk(q, 32'h0000_efcd);
    endtask
    task automatic t_regs;
        for (int i = 0; i < 7; i++) begin
            xfer(1'b0, 4'h7 + i[3:0], 16'h0);
            chk(q, {16'h0, rv[i]});
            xfer(1'b1, 4'h7 + i[3:0], 16'hffff);
            xfer(1'b0, 4'h7 + i[3:0], 16'h0);
            chk(q, {16'h0, wm[i]});
        end
        xfer(1'b1, 4'he, 16'hffff);
        xfer(1'b0, 4'he, 16'h0);
        chk(q, 32'h0);
        chk({8'h0, detect_threshold_o}, 32'hffffff);
    endtask
    task automatic t_filter;
        xfer(1'b1, 4'h9, 16'h0);
        for (int c = 0; c < 16; c++) begin
            xfer(1'b1, 4'h8, {12'h0, c[3:0]});
            @(posedge clk_i);
            chk({26'h0, dc_removal_bypass_o, dc_removal_shift_o},
                {26'h0, c == 0, (c == 0) ? 5'h0 : 5'(c + 1)});
        end
        xfer(1'b1, 4'h9, 16'h0004);
        @(posedge clk_i);
        chk({31'h0, dc_removal_bypass_o}, 32'h1);
    endtask
    task automatic t_cfg;
        for (int m = 0; m < 4; m++) begin
            xfer(1'b1, 4'h9, {10'h201, 4'h0, m[1:0]});
            @(posedge clk_i);
            chk({17'h0, channel0_phase_delay_o, channel0_input_select_o, channel0_short_o,
                 channel0_test_pos_o, channel0_test_neg_o},
                {17'h0, 10'h201, m[1:0], m == 1, m == 2, m == 3});
        end
    endtask
    task automatic t_cal;
        xfer(1'b1, 4'ha, 16'h1234);
        xfer(1'b1, 4'hb, 16'h56ff);
        xfer(1'b1, 4'hc, 16'hfedc);
        xfer(1'b1, 4'hd, 16'hba98);
        @(posedge clk_i);
        chk({8'h0, channel0_offset_o}, 32'h123456);
        chk({8'h0, channel0_gain_o}, 32'hfedcba);
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_regs();
        t_filter();
        t_cfg();
        t_cal();
        t_lanes();
        wrap_up();
    end
    // hang guard, well beyond the fewer than two hundred cycles the tests take
    initial begin
        repeat (4000) @(posedge clk_i);
        fail_count++;
        wrap_up();
    end
endmodule
`default_nettype wire

/* acr_regs_sva.sv */
// acr_regs_sva: port-level checks of the channel calibration bank
// assumes bind onto acr_regs; single clock, sync reset
`timescale 1ns/100ps
`default_nettype none
module acr_regs_chk (
    input wire logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
    input wire logic [5:2]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i, dat_o,
    input wire logic [23:0] detect_threshold_o,
    input wire logic        dc_removal_bypass_o, channel0_short_o,
    input wire logic        channel0_test_pos_o, channel0_test_neg_o,
    input wire logic [4:0]  dc_removal_shift_o,
    input wire logic [9:0]  channel0_phase_delay_o,
    input wire logic [1:0]  channel0_input_select_o
);
    // writes with both low byte lanes (sel_i[1:0] all set) only; partial lanes are left to the bench
    wire logic tk = cyc_i && stb_i && !ack_o;
    wire logic wt = tk && we_i && (sel_i[1:0] == 2'h3);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_pulse: assert property (tk |=> ack_o ##1 !ack_o)
        else $error("ack not a one-cycle answer");
    a_thr_upper: assert property (wt && adr_i == 4'h7 |=>
        ##1 detect_threshold_o[23:8] == $past(dat_i[15:0], 2)) else $error("threshold upper");
    a_thr_lower: assert property (wt && adr_i == 4'h8 |=>
        ##1 detect_threshold_o[7:0] == $past(dat_i[15:8], 2)) else $error("threshold lower");
    a_coeff_shift: assert property (wt && adr_i == 4'h8 && dat_i[3:0] != 4'h0 |=> ##1
        dc_removal_bypass_o || dc_removal_shift_o == {1'b0, $past(dat_i[3:0], 2)} + 5'h01)
        else $error("coefficient shift");
    a_filter_off: assert property (wt && ((adr_i == 4'h8 && dat_i[3:0] == 4'h0) ||
        (adr_i == 4'h9 && dat_i[2])) |=> ##1 dc_removal_bypass_o && dc_removal_shift_o == 5'h00)
        else $error("filter not bypassed");
    a_phase_mux: assert property (wt && adr_i == 4'h9 |=> ##1
        channel0_phase_delay_o == $past(dat_i[15:6], 2) &&
        channel0_input_select_o == $past(dat_i[1:0], 2)) else $error("channel config");
    a_mux_decode: assert property ({channel0_short_o, channel0_test_pos_o,
        channel0_test_neg_o} == {channel0_input_select_o == 2'h1, channel0_input_select_o == 2'h2,
        channel0_input_select_o == 2'h3}) else $error("input decode");
    a_rsvd_read: assert property (tk && !we_i && (adr_i == 4'hb || adr_i == 4'hd) |=>
        dat_o[7:0] == 8'h00 && dat_o[31:16] == 16'h0000) else $error("reserved bits read");
endmodule
bind acr_regs acr_regs_chk acr_regs_chk_i (.*);
`default_nettype wire
